//--- hw/atapw_engine.v
// ata pio data-out and non-data command execution engine
`timescale 1ns/1ps
`default_nettype none
`include "atapw_defines.vh"
module atapw_engine (
  // clock and reset
  input wire clk_sys,
  input wire arst_n,
  // task file writes from the host side
  input wire cmd_wr,
  input wire [7:0] cmd_code,
  input wire [7:0] feat_in,
  input wire [7:0] count_in,
  input wire [7:0] sector_in,
  input wire [15:0] cyl_in,
  input wire [3:0] head_in,
  input wire status_rd,
  // host data port, one byte per strobe
  input wire data_wr,
  input wire [7:0] data_in,
  // media engine
  output reg media_go,
  output reg [1:0] media_op,
  input wire media_done,
  input wire media_err,
  input wire media_found,
  input wire media_idx2,
  // sector buffer write port
  output reg buf_we,
  output reg [9:0] buf_addr,
  output reg [7:0] buf_data,
  // task file state seen by the host
  output reg bsy,
  output reg drq,
  output reg dsc,
  output reg err,
  output reg intrq,
  output reg [7:0] error_reg,
  output reg [7:0] count_out,
  output reg [7:0] sector_out,
  output reg [15:0] cyl_out,
  output reg [3:0] head_out,
  // configuration seen by the rest of the drive
  output reg [7:0] spt,
  output reg [3:0] heads_m1,
  output reg [4:0] multi_size,
  output reg wcache_en,
  output reg retry_en,
  output reg la_en,
  output reg ecc24,
  output reg apm_en,
  output reg [7:0] xfer_mode,
  // diagnostic result from self-test logic
  input wire [7:0] diag_code
);

  // -------------------------------------------------------------
  // states and media operations
  // -------------------------------------------------------------
  localparam [5:0] S_IDLE = 6'h01; // waiting for a command
  localparam [5:0] S_DATA = 6'h02; // drq up, taking bytes
  localparam [5:0] S_MEDIA = 6'h04; // bsy, media busy
  localparam [5:0] S_SEEKW = 6'h08; // command held behind a seek
  localparam [5:0] S_NDATA = 6'h10; // non-data media op
  localparam [5:0] S_DONE = 6'h20; // clear bsy, raise intrq, then idle
  localparam [1:0] OP_WRITE = 2'h0;
  localparam [1:0] OP_VERIFY = 2'h1;
  localparam [1:0] OP_SEEK = 2'h2;
  localparam [1:0] OP_FMT = 2'h3;

  reg [5:0] state; // one-hot state
  reg [7:0] cmd; // latched command code
  reg [7:0] remain; // sectors left (0 means 256)
  reg [4:0] blk_left; // sectors left in this block
  reg [9:0] byte_cnt; // bytes taken in current sector
  reg [9:0] byte_lim; // bytes per sector incl. ecc
  reg seek_busy; // background seek in progress
  reg multi_run; // current command is write multiple

  // -------------------------------------------------------------
  // functions
  // -------------------------------------------------------------
  // first block length: full block or residue
  function [4:0] blk_len;
    input [7:0] cnt;
    input [4:0] sz;
    reg [8:0] c;
    begin
      c = (cnt == 8'h00) ? 9'h100 : {1'b0, cnt};
      blk_len = (c >= {4'h0, sz}) ? sz : c[4:0];
    end
  endfunction

  // valid multiple block size
  function ok_size;
    input [7:0] v;
    begin
      ok_size = (v == 8'h02) || (v == 8'h04) || (v == 8'h08) ||
                (v == 8'h10);
    end
  endfunction

  // write long command class
  function is_wlong;
    input [7:0] c;
    begin
      is_wlong = (c == `ATAPW_CMD_WLONG) || (c == `ATAPW_CMD_WLONG_NR);
    end
  endfunction

  wire data_last = data_wr && (byte_cnt == byte_lim - 10'h001);
  wire more = (remain != 8'h01);

  // -------------------------------------------------------------
  // main sequencer
  // -------------------------------------------------------------
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state <= S_IDLE;
      cmd <= 8'h00;
      remain <= 8'h00;
      blk_left <= 5'h00;
      byte_cnt <= 10'h000;
      byte_lim <= 10'h000;
      seek_busy <= 1'b0;
      multi_run <= 1'b0;
      media_go <= 1'b0;
      media_op <= 2'h0;
      buf_we <= 1'b0;
      buf_addr <= 10'h000;
      buf_data <= 8'h00;
      bsy <= 1'b0;
      drq <= 1'b0;
      dsc <= 1'b1;
      err <= 1'b0;
      intrq <= 1'b0;
      error_reg <= 8'h00;
      count_out <= 8'h00;
      sector_out <= 8'h00;
      cyl_out <= 16'h0000;
      head_out <= 4'h0;
      spt <= 8'h00;
      heads_m1 <= 4'h0;
      multi_size <= 5'h00; // multiple disabled
      wcache_en <= 1'b1; // power-on defaults
      retry_en <= 1'b1;
      la_en <= 1'b1;
      ecc24 <= 1'b0;
      apm_en <= 1'b1;
      xfer_mode <= 8'h00;
    end else begin
      media_go <= 1'b0;
      buf_we <= 1'b0;
      // status read drops the interrupt
      if (status_rd)
        intrq <= 1'b0;
      // background seek finishing raises dsc
      if (seek_busy && media_done) begin
        seek_busy <= 1'b0;
        dsc <= 1'b1;
      end
      case (state)
        S_IDLE: begin
          if (cmd_wr) begin
            cmd <= cmd_code;
            err <= 1'b0;
            error_reg <= 8'h00;
            intrq <= 1'b0;
            remain <= count_in;
            count_out <= count_in;
            sector_out <= sector_in;
            cyl_out <= cyl_in;
            head_out <= head_in;
            bsy <= 1'b1;
            multi_run <= (cmd_code == `ATAPW_CMD_WMUL);
            // always via the hold state: passes at once with no seek
            // running, waits there behind one otherwise
            state <= S_SEEKW;
          end
        end
        S_SEEKW: begin
          // hold bsy until the seek is over, then dispatch
          if (!seek_busy || media_done) begin
            byte_cnt <= 10'h000;
            byte_lim <= `ATAPW_SECT_BYTES;
            case (cmd)
              `ATAPW_CMD_WBUF, `ATAPW_CMD_WSEC, `ATAPW_CMD_WSEC_NR,
              `ATAPW_CMD_FMT: begin
                // ready for the first sector
                bsy <= 1'b0;
                drq <= 1'b1;
                state <= S_DATA;
              end
              `ATAPW_CMD_WLONG, `ATAPW_CMD_WLONG_NR: begin
                // one sector plus host ecc bytes
                byte_lim <= `ATAPW_SECT_BYTES +
                  (ecc24 ? `ATAPW_ECC_LONG : `ATAPW_ECC_SHORT);
                remain <= 8'h01;
                bsy <= 1'b0;
                drq <= 1'b1;
                state <= S_DATA;
              end
              `ATAPW_CMD_WMUL: begin
                if (multi_size == 5'h00) begin
                  // no multiple mode: abort, no data
                  err <= 1'b1;
                  error_reg <= `ATAPW_ERR_ABRT;
                  state <= S_DONE;
                end else begin
                  // first block, no interrupt
                  blk_left <= blk_len(remain, multi_size);
                  bsy <= 1'b0;
                  drq <= 1'b1;
                  state <= S_DATA;
                end
              end
              `ATAPW_CMD_INIT: begin
                // stored without any
                spt <= count_out;
                heads_m1 <= head_out;
                state <= S_DONE;
              end
              `ATAPW_CMD_VER, `ATAPW_CMD_VER_NR: begin
                // verify never raises drq
                media_go <= 1'b1;
                media_op <= OP_VERIFY;
                state <= S_NDATA;
              end
              `ATAPW_CMD_SETF: begin
                // feature decode, unknown codes abort
                case (feat_in)
                  `ATAPW_F_XFER: begin
                    // transfer mode from count
                    if (count_out[7:4] == `ATAPW_XM_SW ||
                        count_out[7:4] == `ATAPW_XM_MW ||
                        count_out[7:4] == `ATAPW_XM_UDMA)
                      xfer_mode <= count_out;
                    else begin
                      err <= 1'b1;
                      error_reg <= `ATAPW_ERR_ABRT;
                    end
                  end
                  `ATAPW_F_APM_ON: apm_en <= 1'b1;
                  `ATAPW_F_APM_OFF: apm_en <= 1'b0;
                  `ATAPW_F_RTY_OFF: retry_en <= 1'b0;
                  `ATAPW_F_RTY_ON: retry_en <= 1'b1;
                  `ATAPW_F_ECC24: ecc24 <= 1'b1;
                  `ATAPW_F_ECC4: ecc24 <= 1'b0;
                  `ATAPW_F_LA_OFF: la_en <= 1'b0;
                  `ATAPW_F_LA_ON: la_en <= 1'b1;
                  `ATAPW_F_WC_ON: wcache_en <= 1'b1;
                  `ATAPW_F_WC_OFF: wcache_en <= 1'b0;
                  // accepted with no local effect
                  `ATAPW_F_OFS_ON, `ATAPW_F_OFS_OFF, `ATAPW_F_REV_OFF,
                  `ATAPW_F_REV_ON, `ATAPW_F_ECC_OFF,
                  `ATAPW_F_ECC_ON: err <= 1'b0;
                  default: begin
                    err <= 1'b1;
                    error_reg <= `ATAPW_ERR_ABRT;
                  end
                endcase
                state <= S_DONE;
              end
              `ATAPW_CMD_SETM: begin
                // block size
                if (ok_size(count_out))
                  multi_size <= count_out[4:0];
                else begin
                  multi_size <= 5'h00;
                  err <= 1'b1;
                  error_reg <= `ATAPW_ERR_ABRT;
                end
                state <= S_DONE;
              end
              `ATAPW_CMD_DIAG: begin
                // result code lands in error register
                error_reg <= diag_code;
                state <= S_DONE;
              end
              default: begin
                if (cmd[7:4] == `ATAPW_CMD_RECAL) begin
                  // seek to cylinder 0
                  cyl_out <= 16'h0000;
                  media_go <= 1'b1;
                  media_op <= OP_SEEK;
                  state <= S_NDATA;
                end else if (cmd[7:4] == `ATAPW_CMD_SEEK) begin
                  // start seek, drop dsc until positioned
                  dsc <= 1'b0;
                  seek_busy <= 1'b1;
                  media_go <= 1'b1;
                  media_op <= OP_SEEK;
                  state <= S_DONE;
                end else begin
                  err <= 1'b1;
                  error_reg <= `ATAPW_ERR_ABRT;
                  state <= S_DONE;
                end
              end
            endcase
          end
        end
        S_DATA: begin
          if (data_wr) begin
            // bytes in order; format words high then low
            buf_we <= 1'b1;
            buf_addr <= byte_cnt;
            buf_data <= data_in;
            byte_cnt <= byte_cnt + 10'h001;
          end
          if (data_last) begin
            byte_cnt <= 10'h000;
            if (multi_run && blk_left != 5'h01 && more) begin
              // stay in drq within a block
              blk_left <= blk_left - 5'h01;
              remain <= remain - 8'h01;
              // address follows every sector, not only block ends
              count_out <= remain - 8'h01;
              sector_out <= sector_out + 8'h01;
              media_go <= 1'b1;
              media_op <= OP_WRITE;
            end else begin
              // sector done: drop drq, raise bsy
              drq <= 1'b0;
              bsy <= 1'b1;
              media_go <= (cmd != `ATAPW_CMD_WBUF);
              media_op <= (cmd == `ATAPW_CMD_FMT) ? OP_FMT : OP_WRITE;
              state <= (cmd == `ATAPW_CMD_WBUF) ? S_DONE : S_MEDIA;
            end
          end
        end
        S_MEDIA: begin
          if (media_done || (media_idx2 && !media_found && !retry_en)) begin
            bsy <= 1'b0;
            intrq <= 1'b1;
            if (media_err || !media_found) begin
              // stop at failing sector, address stays
              err <= 1'b1;
              error_reg <= media_found ? `ATAPW_ERR_ABRT : `ATAPW_ERR_IDNF;
              state <= S_IDLE;
            end else if (more && cmd != `ATAPW_CMD_FMT &&
                         !is_wlong(cmd)) begin
              // next sector or block with interrupt
              remain <= remain - 8'h01;
              count_out <= remain - 8'h01;
              sector_out <= sector_out + 8'h01;
              blk_left <= multi_size;
              drq <= 1'b1;
              state <= S_DATA;
            end else begin
              // address shows last sector written
              count_out <= 8'h00;
              state <= S_IDLE;
            end
          end
        end
        S_NDATA: begin
          if (media_done) begin
            if (media_err) begin
              err <= 1'b1;
              // tnf for recalibrate, else failing address
              error_reg <= (media_op == OP_SEEK) ? `ATAPW_ERR_TNF
                                                 : `ATAPW_ERR_IDNF;
              count_out <= remain;
              state <= S_DONE;
            end else if (media_op == OP_VERIFY && more) begin
              // verify sector by sector so a failure stops in place
              remain <= remain - 8'h01;
              sector_out <= sector_out + 8'h01;
              media_go <= 1'b1;
            end else begin
              if (media_op == OP_VERIFY)
                count_out <= 8'h00;
              state <= S_DONE;
            end
          end
        end
        S_DONE: begin
          // completion: clear bsy, interrupt
          bsy <= 1'b0;
          intrq <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule // atapw_engine
`default_nettype wire

//--- hw/atapw_defines.vh
// constants for the ata pio write and non-data command engine
// Notes on behaviour
// - data-out: drq once first sector acceptable
// - after sector: drq low, bsy, then intrq
// - status read clears interrupt, cycle repeats
// - write buffer fills 512 buffer bytes
// - write sectors: seek, idnf without retries
// - address holds last or failing sector
// - write long adds 4 or 24 ecc bytes
// - write multiple: interrupt per block, not first
// - last partial block is count modulo size
// - multiple error after block write, then stop
// - format track takes 512 bytes then executes
// - format word: sector high, descriptor low
// - non-data: bsy, then intrq until status read
// - init params stored without checking
// - verify: no drq, failing address, remainder
// - recalibrate seeks cylinder 0, else tnf
// - seek sets dsc; commands wait behind seek
// - set features decodes codes, else abort
// - power-on defaults: cache, retry, lookahead, ecc4
// - feature 03h picks transfer mode
// - set multiple accepts 2,4,8,16 only
// - diagnostic result into error register
`ifndef ATAPW_DEFINES_VH
`define ATAPW_DEFINES_VH
// command codes
`define ATAPW_CMD_WBUF 8'he8
`define ATAPW_CMD_WSEC 8'h30
`define ATAPW_CMD_WSEC_NR 8'h31
`define ATAPW_CMD_WLONG 8'h32
`define ATAPW_CMD_WLONG_NR 8'h33
`define ATAPW_CMD_WMUL 8'hc5
`define ATAPW_CMD_FMT 8'h50
`define ATAPW_CMD_INIT 8'h91
`define ATAPW_CMD_VER 8'h40
`define ATAPW_CMD_VER_NR 8'h41
`define ATAPW_CMD_RECAL 4'h1
`define ATAPW_CMD_SEEK 4'h7
`define ATAPW_CMD_SETF 8'hef
`define ATAPW_CMD_SETM 8'hc6
`define ATAPW_CMD_DIAG 8'h90
// feature codes
`define ATAPW_F_XFER 8'h03
`define ATAPW_F_APM_ON 8'h05
`define ATAPW_F_OFS_ON 8'h09
`define ATAPW_F_RTY_OFF 8'h33
`define ATAPW_F_ECC24 8'h44
`define ATAPW_F_LA_OFF 8'h55
`define ATAPW_F_REV_OFF 8'h66
`define ATAPW_F_ECC_OFF 8'h77
`define ATAPW_F_APM_OFF 8'h85
`define ATAPW_F_ECC_ON 8'h88
`define ATAPW_F_OFS_OFF 8'h89
`define ATAPW_F_RTY_ON 8'h99
`define ATAPW_F_LA_ON 8'haa
`define ATAPW_F_ECC4 8'hbb
`define ATAPW_F_REV_ON 8'hcc
`define ATAPW_F_WC_ON 8'h02
`define ATAPW_F_WC_OFF 8'h82
// transfer mode high nibbles
`define ATAPW_XM_SW 4'h1
`define ATAPW_XM_MW 4'h2
`define ATAPW_XM_UDMA 4'h4
// sizes
`define ATAPW_SECT_BYTES 10'h200
`define ATAPW_ECC_SHORT 10'h004
`define ATAPW_ECC_LONG 10'h018
// error register bits
`define ATAPW_ERR_ABRT 8'h04
`define ATAPW_ERR_TNF 8'h02
`define ATAPW_ERR_IDNF 8'h10
`endif

//--- dv/atapw_media_model.sv
// media engine stand-in answering the command engine's media starts
`timescale 1ns/1ps
`default_nettype none
module atapw_media_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // engine side
  input wire logic media_go,
  input wire logic cmd_wr,
  output logic media_done,
  output logic media_err,
  output logic media_found,
  output logic media_idx2,
  // scenario knobs
  input wire logic [7:0] fail_at,
  input wire logic [7:0] dly,
  input wire logic nf
);
  logic busy; // operation in flight
  logic [7:0] left; // cycles to completion
  logic [7:0] nr; // starts since the last command
  // --------------------------------------------
  // one operation at a time, answered after dly
  // --------------------------------------------
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      {busy, left, nr, media_done, media_err, media_idx2} <= '0;
      media_found <= 1'b0;
    end else begin
      media_done <= 1'b0;
      media_idx2 <= 1'b0;
      // error level means nothing between answers, so keep it moving
      media_err <= ~media_err;
      media_found <= !nf;
      if (cmd_wr)
        nr <= 8'h00;
      if (media_go) begin
        busy <= 1'b1;
        left <= dly;
        nr <= nr + 8'h01;
      end else if (busy && left != 8'h00)
        left <= left - 8'h01;
      else if (busy) begin
        busy <= 1'b0;
        media_idx2 <= nf; // id never matched in two revolutions
        media_done <= !nf;
        media_err <= (nr == fail_at);
      end
    end
  end
endmodule // atapw_media_model
`default_nettype wire

//--- dv/atapw_engine_monitor.sv
// protocol checker bound to the command engine's ports
`timescale 1ns/1ps
`default_nettype none
`include "atapw_defines.vh"
module atapw_engine_monitor (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // host strobes
  input wire logic cmd_wr,
  input wire logic status_rd,
  input wire logic data_wr,
  // engine state
  input wire logic bsy,
  input wire logic drq,
  input wire logic dsc,
  input wire logic err,
  input wire logic intrq,
  input wire logic buf_we,
  input wire logic media_done,
  input wire logic [7:0] error_reg,
  input wire logic [4:0] multi_size
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // --------------------------------------------
  // handshake and status relations
  // --------------------------------------------
  chk_bsy_on_cmd: assert property (cmd_wr && !bsy && !drq |=> bsy)
    else $error("bsy missing after accepted command");
  chk_drq_bsy_excl: assert property (!(drq && bsy))
    else $error("drq and bsy high together");
  chk_drq_fall: assert property ($fell(drq) |-> bsy || err)
    else $error("drq dropped without bsy");
  chk_intrq_clear: assert property (status_rd && intrq |=> !intrq)
    else $error("intrq survived status read");
  chk_intrq_idle: assert property ($rose(intrq) |-> !bsy)
    else $error("intrq raised while busy");
  chk_buf_from_host: assert property (
    buf_we |-> $past(data_wr) || $past(data_wr, 2))
    else $error("buffer write without host byte");
  chk_seek_done: assert property (!dsc && media_done |=> dsc)
    else $error("seek complete flag not set");
  chk_abort_code: assert property ($rose(err) |-> error_reg inside
    {`ATAPW_ERR_ABRT, `ATAPW_ERR_TNF, `ATAPW_ERR_IDNF})
    else $error("error flag with unknown code");
  chk_multi_legal: assert property (multi_size inside {0, 2, 4, 8, 16})
    else $error("illegal block size stored");
  // main scenarios reached
  cov_data_out: cover property ($rose(drq));
  cov_seek: cover property ($fell(dsc));
  cov_error: cover property ($rose(err));
endmodule // atapw_engine_monitor
bind atapw_engine atapw_engine_monitor atapw_engine_monitor_i (.*);
`default_nettype wire

//--- dv/atapw_engine_test.sv
// self-checking bench for the ata pio write and non-data engine
`timescale 1ns/1ps
`default_nettype none
`include "atapw_defines.vh"
module atapw_engine_test;
  // host side drives
  logic clk_sys = 0, arst_n = 0, cmd_wr = 0, status_rd = 0, data_wr = 0;
  logic [7:0] cmd_code = 0, feat_in = 0, count_in = 0, sector_in = 0;
  logic [7:0] data_in = 0, diag_code = 8'h01, fail_at = 0, dly = 8'h0a;
  logic [15:0] cyl_in = 16'h0123;
  logic [3:0] head_in = 4'h2;
  logic nf = 0;
  // engine outputs
  logic media_go, media_done, media_err, media_found, media_idx2, buf_we;
  logic bsy, drq, dsc, err, intrq, wcache_en, retry_en, la_en, ecc24, apm_en;
  logic [1:0] media_op;
  logic [9:0] buf_addr;
  logic [7:0] buf_data, error_reg, count_out, sector_out, spt, xfer_mode;
  logic [15:0] cyl_out;
  logic [3:0] head_out, heads_m1;
  logic [4:0] multi_size;
  logic [4:0] cfg = 5'h1d; // expected {wcache, retry, lookahead, ecc24, apm}
  int mismatches = 0, checks = 0, irqs = 0, gos = 0, wes = 0, drqs = 0;
  // feature code, config bit index, new value
  logic [15:0] ft [10] = '{16'h8240, 16'h0241, 16'h3330, 16'h9931, 16'h5520,
    16'haa21, 16'h8500, 16'h0501, 16'hbb10, 16'h4411};
  atapw_engine atapw_engine_i (.*);
  atapw_media_model atapw_media_model_i (.*);
  initial forever #25 clk_sys = ~clk_sys;
  // event counters
  always @(posedge intrq) irqs++;
  always @(posedge media_go) gos++;
  always @(posedge drq) drqs++;
  always @(posedge clk_sys) if (buf_we === 1'b1) wes++;
  // --------------------------------------------
  // host access tasks
  // --------------------------------------------
  task automatic check(input string n, input logic [15:0] s, e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim;
    if (mismatches == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] c, f, n, s);
    @(negedge clk_sys);
    {cmd_code, feat_in, count_in, sector_in} = {c, f, n, s};
    cmd_wr = 1;
    @(negedge clk_sys);
    cmd_wr = 0;
  endtask
  // bounded wait, so a stuck engine shows as a mismatch
  task automatic wait_for(ref logic f, input string n);
    for (int i = 0; i < 3000 && f !== 1'b1; i++) @(negedge clk_sys);
    check(n, f, 1'b1);
  endtask
  task automatic ack;
    wait_for(intrq, "intrq");
    status_rd = 1;
    @(negedge clk_sys);
    status_rd = 0;
    @(negedge clk_sys);
    check("intrq_clear", intrq, 1'b0);
  endtask
  task automatic send(input int n);
    for (int i = 0; i < n; i++) begin
      data_wr = 1;
      data_in = i[7:0];
      @(negedge clk_sys);
    end
    data_wr = 0;
  endtask
  // --------------------------------------------
  // watchdog and main sequence
  // --------------------------------------------
  initial begin
    repeat (40000) @(posedge clk_sys);
    mismatches++;
    end_sim;
  end
  initial begin
    repeat (2) @(negedge clk_sys);
    arst_n = 1;
    check("dsc_rst", dsc, 1'b1);
    check("cfg_rst", {wcache_en, retry_en, la_en, ecc24, apm_en}, cfg);
    check("multi_rst", multi_size, 5'h00);
    cmd(`ATAPW_CMD_WSEC, 0, 2, 8'h05);
    wait_for(drq, "drq");
    send(512);
    @(negedge clk_sys);
    check("sector_end", {drq, bsy}, 2'b01);
    wait_for(intrq, "intrq");
    check("drq_again", {drq, bsy}, 2'b10);
    ack;
    send(512);
    ack;
    check("last_sector", sector_out, 8'h06);
    wes = 0;
    cmd(`ATAPW_CMD_WBUF, 0, 0, 0);
    wait_for(drq, "drq");
    send(512);
    ack;
    check("buf_bytes", wes, 512);
    check("buf_last", {buf_addr, buf_data}, {10'h1ff, 8'hff});
    cmd(`ATAPW_CMD_FMT, 0, 8'h02, 0);
    wait_for(drq, "drq");
    send(512);
    @(negedge clk_sys);
    check("format_run", {drq, bsy, media_op}, 4'b0111);
    ack;
    cmd(`ATAPW_CMD_WMUL, 0, 2, 0);
    ack;
    check("mul_off", {err, error_reg}, {1'b1, `ATAPW_ERR_ABRT});
    cmd(`ATAPW_CMD_SETM, 0, 3, 0);
    ack;
    check("setm_bad", {err, multi_size}, 6'h20);
    for (int i = 4; i > 0; i--) begin
      cmd(`ATAPW_CMD_SETM, 0, 8'h01 << i, 0);
      ack;
      check("setm_ok", {err, multi_size}, 16'h1 << i);
    end
    irqs = 0;
    gos = 0;
    cmd(`ATAPW_CMD_WMUL, 0, 3, 8'h10);
    wait_for(drq, "drq");
    send(1024);
    ack;
    check("block2_drq", drq, 1'b1);
    send(512);
    ack;
    check("mul_irqs", irqs, 2);
    check("mul_sectors", gos, 3);
    check("mul_last", sector_out, 8'h12);
    foreach (ft[k]) begin
      cmd(`ATAPW_CMD_SETF, ft[k][15:8], 8'h80, 0);
      ack;
      cfg[ft[k][7:4]] = ft[k][0];
      check("feature", {err, wcache_en, retry_en, la_en, ecc24, apm_en},
        cfg);
    end
    cmd(`ATAPW_CMD_SETF, `ATAPW_F_XFER, 8'h42, 0);
    ack;
    check("xfer_mode", xfer_mode, 8'h42);
    cmd(`ATAPW_CMD_SETF, 8'h11, 8'h80, 0);
    ack;
    check("feat_bad", {err, error_reg}, {1'b1, `ATAPW_ERR_ABRT});
    cmd(`ATAPW_CMD_WLONG, 0, 1, 8'h01);
    wait_for(drq, "drq");
    send(535);
    check("ecc_wait", drq, 1'b1);
    @(negedge clk_sys);
    send(1);
    @(negedge clk_sys);
    check("ecc_done", {drq, bsy}, 2'b01);
    ack;
    cmd(`ATAPW_CMD_SETF, `ATAPW_F_RTY_OFF, 8'h80, 0);
    ack;
    nf = 1;
    cmd(`ATAPW_CMD_WSEC, 0, 1, 8'h07);
    wait_for(drq, "drq");
    send(512);
    ack;
    check("idnf", {err, error_reg}, {1'b1, `ATAPW_ERR_IDNF});
    nf = 0;
    fail_at = 2;
    drqs = 0;
    cmd(`ATAPW_CMD_VER, 0, 3, 8'h01);
    ack;
    check("verify_drq", drqs, 0);
    check("verify_fail", {err, sector_out, count_out}, 17'h10202);
    fail_at = 1;
    cmd(8'h10, 0, 0, 0);
    ack;
    check("recal_fail", error_reg, `ATAPW_ERR_TNF);
    check("recal_cyl", cyl_out, 16'h0000);
    fail_at = 0;
    dly = 8'h3c;
    cmd(8'h70, 0, 0, 0);
    ack;
    check("seek_dsc", dsc, 1'b0);
    head_in = 4'h7;
    cmd(`ATAPW_CMD_INIT, 0, 8'h3f, 0);
    check("held", bsy, 1'b1);
    ack;
    check("init", {dsc, spt, heads_m1}, {1'b1, 8'h3f, 4'h7});
    check("init_head", head_out, 4'h7);
    cmd(`ATAPW_CMD_DIAG, 0, 0, 0);
    ack;
    check("diag", error_reg, 8'h01);
    end_sim;
  end
endmodule // atapw_engine_test
`default_nettype wire
